// ===== hw/bpsc_top.sv
/*
  Backplane system-control logic: bus timeout, system reset, system fail,
  longword, interrupt levels, address drivers, bus grant pass-through and
  serial port B steering, with an AHB-Lite register slave.
  Assumes one AHB-Lite master, pins synchronous to hclk, and an outside
  wire resolver for every out/oe pin pair.
*/
`timescale 1ns/1ps
`default_nettype none
module bpsc_top #(
  parameter logic [15:0] BTO_LIMIT = 16'(bpsc_pkg::BTO_CYCLES)
) (
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic irq_out,
  // Bus timeout and bus error
  input wire logic [1:0] ds_n,
  input wire logic berr_n_in,
  output logic berr_n_out,
  output logic berr_oe,
  input wire logic master_active,
  output logic local_berr_exc,
  // System reset
  input wire logic reset_switch,
  input wire logic watchdog_timeout,
  input wire logic remote_reset_n,
  input wire logic sysreset_n_in,
  output logic sysreset_n_out,
  output logic sysreset_oe,
  output logic board_reset_n,
  // System fail
  input wire logic sysfail_n_in,
  output logic sysfail_n_out,
  output logic sysfail_oe,
  // Longword and address
  input wire logic local_xfer_32,
  input wire logic lword_n_in,
  output logic lword_n_out,
  output logic lword_oe,
  output logic slave_access_32,
  input wire logic [15:0] local_addr,
  input wire logic [15:0] addr_in,
  output logic [15:0] addr_out,
  output logic addr_oe,
  output logic [15:0] slave_addr,
  // Interrupt request lines, index 0 is level 1
  input wire logic [6:0] irq_n_in,
  output logic irq3_n_out,
  output logic irq3_oe,
  output logic [2:0] irq_level,
  // Bus grant daisy chain
  input wire logic [3:0] bg_in_n,
  output logic [3:0] bg_out_n,
  input wire logic bus_request_local,
  // Serial port B
  input wire logic serial_tx_clock_out_b,
  input wire logic serial_terminal_ready_out_b,
  output logic serial_rx_clock_in_b,
  output logic serial_carrier_detect_in_b,
  output logic port_b_tx_element_timing_dce,
  output logic port_b_tx_element_timing_oe,
  input wire logic port_b_rx_element_timing_in,
  output logic port_b_rx_element_timing_dce,
  output logic port_b_rx_element_timing_oe,
  input wire logic dtr_in,
  output logic dtr_out,
  output logic dtr_oe
);

  // Whole state of the block
  typedef struct packed {
    logic [15:0] ctrl;
    logic [3:0] int_stat;
    logic [3:0] int_mask;
    logic dp_wr; // Write data phase pending
    logic [1:0] dp_idx; // Register index of that phase
    logic [31:0] rdata;
    logic berr_drive;
    logic berr_exc;
    logic [7:0] pwrup_cnt;
    logic sysreset_drive;
    logic board_rst;
    logic sysreset_q;
    logic sysfail_q;
    logic lword_slave;
    logic [15:0] slave_addr;
  } bpsc_state_t;

  bpsc_state_t state_reg;
  bpsc_state_t state_next;
  bpsc_pkg::bpsc_ctrl_t ctrl; // Typed view of the control word
  logic strobe; // Any data strobe active
  logic expired; // Timeout counter reached its limit
  logic [3:0] int_evt; // Event pulses into the sticky bits
  logic [31:0] status_word; // Live status for reads
  logic addr_take; // Address phase accepted
  logic sysreset_cause; // Any reason to drive system reset

  assign ctrl = state_reg.ctrl;
  assign strobe = ~&ds_n;

  // Strobe timeout counter
  bpsc_timeout #(
    .LIMIT(BTO_LIMIT)
  ) u_timeout (
    .hclk(hclk),
    .hresetn(hresetn),
    .strobe(strobe),
    .expired(expired)
  );

  // Interrupt priority encoder, each level only when its irq_en bit is set
  bpsc_irq_prio u_irq (
    .hclk(hclk),
    .hresetn(hresetn),
    .irq_n(irq_n_in),
    .irq_en(ctrl.irq_en),
    .level(irq_level)
  );

  // Causes of system reset while system controller
  always_comb begin
    sysreset_cause = reset_switch || watchdog_timeout || !remote_reset_n
      || (state_reg.pwrup_cnt != 8'(bpsc_pkg::PWRUP_CYCLES));
  end

  // Events that set sticky interrupt bits; edges only, so a held line
  // does not keep re-setting a bit that software just cleared
  always_comb begin
    int_evt = '0;
    int_evt[bpsc_pkg::INT_TIMEOUT] = ctrl.syscon && expired && !state_reg.berr_drive;
    int_evt[bpsc_pkg::INT_MASTER_BERR] = master_active && !berr_n_in && !state_reg.berr_exc;
    int_evt[bpsc_pkg::INT_SYSRESET] = !sysreset_n_in && !state_reg.sysreset_q;
    int_evt[bpsc_pkg::INT_SYSFAIL] = !sysfail_n_in && !state_reg.sysfail_q;
  end

  // Live status word
  always_comb begin
    status_word = '0;
    status_word[bpsc_pkg::ST_SYSFAIL] = !sysfail_n_in;
    status_word[bpsc_pkg::ST_BERR] = !berr_n_in;
    status_word[bpsc_pkg::ST_SYSRESET] = !sysreset_n_in;
    status_word[bpsc_pkg::ST_IRQ_LO +: 3] = irq_level;
    status_word[bpsc_pkg::ST_LWORD] = state_reg.lword_slave;
    status_word[bpsc_pkg::ST_TIMEOUT] = expired;
  end

  assign addr_take = hsel && hready && htrans[1];

  // Next state
  always_comb begin
    state_next = state_reg;
    // Bus slave: zero wait, read data captured in the address phase
    state_next.dp_wr = addr_take && hwrite;
    if (addr_take) begin
      state_next.dp_idx = haddr[3:2];
    end
    if (addr_take && !hwrite) begin
      case (haddr[3:2])
        bpsc_pkg::REG_CTRL: state_next.rdata = {16'h0000, state_reg.ctrl};
        bpsc_pkg::REG_STATUS: state_next.rdata = status_word;
        bpsc_pkg::REG_INT_STAT: state_next.rdata = {28'h0000000, state_reg.int_stat};
        bpsc_pkg::REG_INT_MASK: state_next.rdata = {28'h0000000, state_reg.int_mask};
        default: state_next.rdata = '0;
      endcase
    end
    // Write data phase
    if (state_reg.dp_wr) begin
      case (state_reg.dp_idx)
        bpsc_pkg::REG_CTRL: state_next.ctrl = hwdata[15:0];
        bpsc_pkg::REG_INT_STAT: state_next.int_stat = state_reg.int_stat & ~hwdata[3:0];
        bpsc_pkg::REG_INT_MASK: state_next.int_mask = hwdata[3:0];
        default: state_next.ctrl = state_reg.ctrl;
      endcase
    end
    // A new event wins over a clear in the same cycle
    state_next.int_stat = state_next.int_stat | int_evt;
    state_next.berr_drive = ctrl.syscon && strobe && (state_reg.berr_drive || expired);
    state_next.berr_exc = master_active && !berr_n_in;
    // Power-up stretch after reset release
    if (state_reg.pwrup_cnt != 8'(bpsc_pkg::PWRUP_CYCLES)) begin
      state_next.pwrup_cnt = state_reg.pwrup_cnt + 8'h01;
    end
    state_next.sysreset_drive = ctrl.syscon && sysreset_cause;
    state_next.board_rst = !sysreset_n_in || state_reg.sysreset_drive;
    state_next.sysreset_q = !sysreset_n_in;
    state_next.sysfail_q = !sysfail_n_in;
    if (!master_active && strobe) begin
      state_next.lword_slave = !lword_n_in;
      state_next.slave_addr = addr_in;
    end
  end

  // Register the state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Bus slave answers at once, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = state_reg.rdata;
  assign irq_out = |(state_reg.int_stat & state_reg.int_mask);

  // Open-drain bus error
  assign berr_n_out = 1'b0;
  assign berr_oe = state_reg.berr_drive;
  assign local_berr_exc = state_reg.berr_exc;

  // System reset and board reset
  assign sysreset_n_out = 1'b0;
  assign sysreset_oe = state_reg.sysreset_drive;
  assign board_reset_n = !state_reg.board_rst;

  assign sysfail_n_out = 1'b0;
  assign sysfail_oe = !ctrl.syscon && ctrl.board_failure_flag;

  assign lword_n_out = !local_xfer_32;
  assign lword_oe = master_active;
  assign slave_access_32 = state_reg.lword_slave;

  assign addr_out = local_addr;
  assign addr_oe = master_active;
  assign slave_addr = state_reg.slave_addr;

  assign irq3_n_out = 1'b0;
  assign irq3_oe = ctrl.irq3_out_en && ctrl.irq3_out_req;

  // Grant chain; only the configured level may be held back
  always_comb begin
    bg_out_n = bg_in_n;
    bg_out_n[ctrl.grant_level] = bg_in_n[ctrl.grant_level] || bus_request_local;
  end

  // Serial clocks are steered, not registered, so edges keep their phase
  // tx element timing in DCE
  assign port_b_tx_element_timing_dce = serial_tx_clock_out_b;
  assign port_b_tx_element_timing_oe = ctrl.port_b_dce;
  assign port_b_rx_element_timing_dce = serial_tx_clock_out_b;
  assign port_b_rx_element_timing_oe = ctrl.port_b_dce;
  assign serial_rx_clock_in_b = !ctrl.port_b_dce && ctrl.rx_clock_opt
    && port_b_rx_element_timing_in;
  assign serial_carrier_detect_in_b = ctrl.port_b_dce && dtr_in;
  assign dtr_out = serial_terminal_ready_out_b;
  assign dtr_oe = !ctrl.port_b_dce;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Timeout seen as syscon under a live strobe
  sequence s_timeout;
    ctrl.syscon && strobe && expired;
  endsequence

  chk_timeout_berr: assert property (s_timeout |=> berr_oe)
    else $error("bus error not driven on timeout");

  chk_berr_release: assert property (!strobe |=> !berr_oe)
    else $error("bus error held after strobe release");

  chk_master_exc: assert property (
    (master_active && !berr_n_in) |=> local_berr_exc)
    else $error("bus error exception missing");

  chk_sysreset_drive: assert property (
    (ctrl.syscon && reset_switch) |=> sysreset_oe)
    else $error("system reset not driven");

  chk_board_reset: assert property (
    !sysreset_n_in |=> !board_reset_n)
    else $error("board not reset by system reset");

  chk_sysfail_drive: assert property (
    sysfail_oe == (!ctrl.syscon && ctrl.board_failure_flag))
    else $error("sysfail drive wrong");

  chk_lword_master: assert property (
    master_active |-> (lword_oe && lword_n_out == !local_xfer_32))
    else $error("longword wrong as master");

  chk_grant_hold: assert property (
    bus_request_local |-> bg_out_n[ctrl.grant_level])
    else $error("grant passed while requesting");

  chk_dtr_dte: assert property (
    !ctrl.port_b_dce |-> (dtr_oe && !serial_carrier_detect_in_b))
    else $error("terminal ready misrouted");

endmodule
`default_nettype wire

// ===== hw/bpsc_pkg.sv
/*
  Package for the backplane system-control block: register map, control
  field positions, interrupt bits, timing constants and carrier structs.
  Assumes a 200 MHz hclk and a single AHB-Lite master.
*/
package bpsc_pkg;

  // Timing
  localparam int CLK_NS = 5;
  localparam int BTO_MIN_US = 72;
  localparam int BTO_MAX_US = 82;
  localparam int BTO_CYCLES = (BTO_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int PWRUP_NS = 200;
  localparam int PWRUP_CYCLES = (PWRUP_NS + CLK_NS - 1) / CLK_NS;

  // Register word indices (byte address bits 3:2)
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;
  localparam logic [1:0] REG_INT_STAT = 2'h2;
  localparam logic [1:0] REG_INT_MASK = 2'h3;

  // Control register layout
  typedef struct packed {
    logic board_failure_flag; // 15
    logic rx_clock_opt; // 14: DTE rx timing feeds controller
    logic [1:0] grant_level; // 13:12
    logic irq3_out_req; // 11
    logic [6:0] irq_en; // 10:4, level 7..1
    logic irq3_out_en; // 3
    logic port_b_dce; // 2
    logic rsvd; // 1
    logic syscon; // 0
  } bpsc_ctrl_t;
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // Interrupt bit positions
  localparam int INT_W = 4;
  localparam int INT_TIMEOUT = 0;
  localparam int INT_MASTER_BERR = 1;
  localparam int INT_SYSRESET = 2;
  localparam int INT_SYSFAIL = 3;

  // Status register bit positions
  localparam int ST_SYSFAIL = 0;
  localparam int ST_BERR = 1;
  localparam int ST_SYSRESET = 2;
  localparam int ST_IRQ_LO = 3;
  localparam int ST_LWORD = 6;
  localparam int ST_TIMEOUT = 7;

  // Open-drain or three-state pin seen from the block
  typedef struct packed {
    logic out;
    logic oe;
  } bpsc_pin_t;

endpackage

// ===== hw/bpsc_timeout.sv
/*
  Data strobe timeout counter. Counts while the strobe is active and
  flags expiry once the limit is reached. Assumes strobe is synchronous.
*/
`timescale 1ns/1ps
`default_nettype none
module bpsc_timeout #(
  parameter logic [15:0] LIMIT = 16'(bpsc_pkg::BTO_CYCLES)
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic strobe,
  output logic expired
);

  // Whole state of the counter
  typedef struct packed {
    logic [15:0] count;
    logic expired;
  } bpsc_to_state_t;

  bpsc_to_state_t state_reg;
  bpsc_to_state_t state_next;

  // Next state: restart on every released strobe
  always_comb begin
    state_next = state_reg;
    if (!strobe) begin
      state_next.count = 16'h0000;
      state_next.expired = 1'b0;
    end else if (state_reg.count != LIMIT) begin
      state_next.count = state_reg.count + 16'h0001;
    end
    if (strobe && state_next.count == LIMIT) begin
      state_next.expired = 1'b1;
    end
  end

  // Register the state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign expired = state_reg.expired;

  // Expiry never comes before the limit
  chk_timeout_early: assert property (
    @(posedge hclk) disable iff (!hresetn)
    expired |-> state_reg.count == LIMIT)
    else $error("timeout flagged before limit");

endmodule
`default_nettype wire

// ===== hw/bpsc_irq_prio.sv
/*
  Interrupt priority encoder for seven backplane request levels.
  Assumes active-low request lines sampled on hclk.
*/
`timescale 1ns/1ps
`default_nettype none
module bpsc_irq_prio (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [6:0] irq_n,
  input wire logic [6:0] irq_en,
  output logic [2:0] level
);

  // Whole state: the encoded level
  typedef struct packed {
    logic [2:0] level;
  } bpsc_irq_state_t;

  bpsc_irq_state_t state_reg;
  bpsc_irq_state_t state_next;

  always_comb begin
    state_next.level = 3'h0;
    for (int i = 0; i < 7; i++) begin
      // Later, higher levels overwrite lower ones
      if (!irq_n[i] && irq_en[i]) begin
        state_next.level = 3'(i + 1);
      end
    end
  end

  // Register the level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign level = state_reg.level;

  // Level seven beats all others
  chk_irq_top: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (!irq_n[6] && irq_en[6]) |=> level == 3'h7)
    else $error("level seven not given priority");

endmodule
`default_nettype wire

// ===== bench/bpsc_far_model.sv
/*
  Far-side backplane master: runs data strobe cycles with an address and
  a longword mark, and gives the strobes up early when bus error shows.
  Assumes the bench resolves the bus error wire with a pull-up.
*/
`timescale 1ns/1ps
`default_nettype none
module bpsc_far_model (
  input wire logic hclk,
  input wire logic berr_n,
  output logic [1:0] ds_n,
  output logic lword_n,
  output logic [15:0] addr
);
  // Idle: strobes pulled up, address lines carry junk
  initial begin
    ds_n = 2'h3;
    lword_n = 1'b1;
    addr = 16'hFFFF;
  end

  // One strobe cycle of up to n clocks; took counts clocks held
  task automatic cycle(input int n, input logic l32, input logic [15:0] a, output int took);
    took = 0;
    @(posedge hclk);
    addr <= a;
    lword_n <= !l32;
    @(posedge hclk);
    ds_n <= 2'h0;
    // strobes held for n clocks, or until bus error seen
    // Bus error is taken at the edge, so the release goes out on that edge
    while (took < n) begin
      @(posedge hclk);
      took++;
      if (berr_n === 1'b0) break;
    end
    // Released lines show the inverse, not the old value
    ds_n <= 2'h3;
    lword_n <= l32;
    addr <= ~a;
  endtask
endmodule
`default_nettype wire

// ===== bench/tb_backplane_sysctl_signals.sv
/*
  Self-checking bench for the backplane system-control block.
  Assumes a single AHB-Lite master and pull-ups on the open-drain lines.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_backplane_sysctl_signals;
  localparam int LIM = 20; // Shortened strobe timeout
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, master_active = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic reset_switch = 1'b0, watchdog_timeout = 1'b0, remote_reset_n = 1'b1, sr_drv = 1'b1;
  logic local_xfer_32 = 1'b0, bus_request_local = 1'b0, serial_tx_clock_out_b = 1'b0;
  logic serial_terminal_ready_out_b = 1'b0, rx_drv = 1'b0, dtr_drv = 1'b0;
  logic [15:0] local_addr = 16'h0;
  logic [6:0] irq_drv = 7'h7F;
  logic [3:0] bg_in_n = 4'hF;
  logic hreadyout, hresp, irq_out, berr_n_out, berr_oe, local_berr_exc, sysreset_n_out;
  logic sysreset_oe, board_reset_n, sysfail_n_out, sysfail_oe, lword_n_out, lword_oe;
  logic slave_access_32, addr_oe, irq3_n_out, irq3_oe, serial_rx_clock_in_b;
  logic serial_carrier_detect_in_b, port_b_tx_element_timing_dce, port_b_tx_element_timing_oe;
  logic port_b_rx_element_timing_dce, port_b_rx_element_timing_oe, dtr_out, dtr_oe;
  logic [31:0] hrdata;
  logic [15:0] addr_out, slave_addr, addr_in;
  logic [2:0] irq_level;
  logic [3:0] bg_out_n;
  logic [1:0] ds_n;
  logic lword_n_in;
  int error_cnt = 0, total_checks = 0;
  // Wire resolution of open-drain and two-way lines
  wire hready = hreadyout;
  wire berr_n_in = berr_oe ? berr_n_out : 1'b1;
  wire sysreset_n_in = sr_drv & !(sysreset_oe & !sysreset_n_out);
  wire sysfail_n_in = sysfail_oe ? sysfail_n_out : 1'b1;
  wire [6:0] irq_n_in = {irq_drv[6:3], irq_drv[2] & !(irq3_oe & !irq3_n_out), irq_drv[1:0]};
  wire port_b_rx_element_timing_in = port_b_rx_element_timing_oe ? port_b_rx_element_timing_dce : rx_drv;
  wire dtr_in = dtr_oe ? dtr_out : dtr_drv;

  always #2.5 hclk = ~hclk;

  bpsc_top #(.BTO_LIMIT(16'(LIM))) DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .irq_out, .ds_n, .berr_n_in,
    .berr_n_out, .berr_oe, .master_active, .local_berr_exc, .reset_switch, .watchdog_timeout,
    .remote_reset_n, .sysreset_n_in, .sysreset_n_out, .sysreset_oe, .board_reset_n,
    .sysfail_n_in, .sysfail_n_out, .sysfail_oe, .local_xfer_32, .lword_n_in, .lword_n_out,
    .lword_oe, .slave_access_32, .local_addr, .addr_in, .addr_out, .addr_oe, .slave_addr,
    .irq_n_in, .irq3_n_out, .irq3_oe, .irq_level, .bg_in_n, .bg_out_n, .bus_request_local,
    .serial_tx_clock_out_b, .serial_terminal_ready_out_b, .serial_rx_clock_in_b,
    .serial_carrier_detect_in_b, .port_b_tx_element_timing_dce, .port_b_tx_element_timing_oe,
    .port_b_rx_element_timing_in, .port_b_rx_element_timing_dce, .port_b_rx_element_timing_oe,
    .dtr_in, .dtr_out, .dtr_oe);

  bpsc_far_model far (.hclk, .berr_n(berr_n_in), .ds_n, .lword_n(lword_n_in), .addr(addr_in));

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One single-word transfer; waits for hready in both phases
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    // Start right after an edge, whatever the caller did before
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
    @(posedge hclk);
    #1;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk(r, e);
    chk(hresp, 1'b0);
  endtask

  // Lets a registered output settle, bounded
  task automatic settle;
    repeat (4) @(posedge hclk);
    #1;
  endtask

  // Strobe timeout, restart, hold, exception and interrupt flow
  task automatic t_timeout;
    int took;
    int i;
    rd(32'h0, 32'h0);
    rd(32'hC, 32'h0);
    wr(32'h0, 32'h1);
    master_active <= 1'b1;
    far.cycle(LIM - 5, 1'b0, 16'h0, took);
    far.cycle(LIM - 5, 1'b0, 16'h0, took);
    chk(berr_oe, 1'b0);
    far.cycle(4 * LIM, 1'b0, 16'h0, took);
    // Bus error is driven one edge after expiry and seen at the next
    chk(32'(took), 32'(LIM + 2));
    @(posedge hclk);
    #1;
    chk(local_berr_exc, 1'b1);
    for (i = 0; i < 8 && berr_oe !== 1'b0; i++) @(posedge hclk);
    chk(32'(i <= 2), 32'h1);
    master_active <= 1'b0;
    rd(32'h8, 32'h3);
    chk(irq_out, 1'b0);
    wr(32'hC, 32'h1);
    chk(irq_out, 1'b1);
    wr(32'h8, 32'h1);
    chk(irq_out, 1'b0);
    wr(32'h8, 32'h2);
    rd(32'h8, 32'h0);
    $display("Timeout test done");
  endtask

  // Switch, watchdog and remote reset causes as controller, then the line as input
  task automatic t_reset;
    int c;
    for (c = 0; c < 3; c++) begin
      if (c == 0) reset_switch <= 1'b1;
      else if (c == 1) watchdog_timeout <= 1'b1;
      else remote_reset_n <= 1'b0;
      settle();
      chk(sysreset_oe, 1'b1);
      chk(board_reset_n, 1'b0);
      reset_switch <= 1'b0;
      watchdog_timeout <= 1'b0;
      remote_reset_n <= 1'b1;
      repeat (100) if (sysreset_oe !== 1'b0) @(posedge hclk);
      settle();
      chk(board_reset_n, 1'b1);
    end
    wr(32'h0, 32'h0);
    sr_drv <= 1'b0;
    settle();
    chk(sysreset_oe, 1'b0);
    chk(board_reset_n, 1'b0);
    sr_drv <= 1'b1;
    repeat (100) if (board_reset_n !== 1'b1) @(posedge hclk);
    rd(32'h8, 32'h4);
    $display("Reset test done");
  endtask

  // System fail, longword, address and slave sampling
  task automatic t_bus;
    int took;
    int x;
    wr(32'h0, 32'h8000);
    chk(sysfail_oe, 1'b1);
    rd(32'h4, 32'h1);
    wr(32'h0, 32'h8001);
    chk(sysfail_oe, 1'b0);
    master_active <= 1'b1;
    local_addr <= 16'hA55A;
    for (x = 0; x < 2; x++) begin
      local_xfer_32 <= x[0];
      @(posedge hclk);
      #1;
      chk({lword_oe, lword_n_out}, {1'b1, !x[0]});
      chk({addr_oe, addr_out}, {1'b1, 16'hA55A});
    end
    master_active <= 1'b0;
    @(posedge hclk);
    #1;
    chk({lword_oe, addr_oe}, 2'h0);
    far.cycle(3, 1'b1, 16'h1234, took);
    settle();
    chk({slave_access_32, slave_addr}, {1'b1, 16'h1234});
    rd(32'h4, 32'h40);
    far.cycle(3, 1'b0, 16'hC3A5, took);
    settle();
    chk({slave_access_32, slave_addr}, {1'b0, 16'hC3A5});
    $display("Bus test done");
  endtask

  // Priority levels, level three output, grant chain
  task automatic t_irq;
    logic [6:0] pat [5] = '{7'h7F, 7'h7E, 7'h7C, 7'h00, 7'h3B};
    logic [2:0] lvl [5] = '{3'h0, 3'h1, 3'h2, 3'h7, 3'h7};
    int i;
    wr(32'h0, 32'h7F0);
    for (i = 0; i < 5; i++) begin
      irq_drv <= pat[i];
      settle();
      chk(irq_level, lvl[i]);
    end
    // Only level three enabled: level seven must be masked out
    wr(32'h0, 32'h40);
    settle();
    chk(irq_level, 3'h3);
    irq_drv <= 7'h7F;
    wr(32'h0, 32'h808);
    chk({irq3_oe, irq3_n_out}, 2'h2);
    wr(32'h0, 32'h800);
    chk(irq3_oe, 1'b0);
    bg_in_n <= 4'h4;
    @(posedge hclk);
    #1;
    chk(bg_out_n, 4'h4);
    bus_request_local <= 1'b1;
    @(posedge hclk);
    #1;
    chk(bg_out_n, 4'h5);
    bus_request_local <= 1'b0;
    $display("Interrupt test done");
  endtask

  // Port B steering in both modes
  task automatic t_serial;
    int v;
    for (v = 0; v < 2; v++) begin
      wr(32'h0, 32'h4);
      serial_tx_clock_out_b <= v[0];
      dtr_drv <= !v[0];
      @(posedge hclk);
      #1;
      chk({port_b_tx_element_timing_oe, port_b_tx_element_timing_dce}, {1'b1, v[0]});
      chk({port_b_rx_element_timing_oe, port_b_rx_element_timing_dce}, {1'b1, v[0]});
      chk({dtr_oe, serial_carrier_detect_in_b}, {1'b0, !v[0]});
      wr(32'h0, 32'h4000);
      rx_drv <= v[0];
      serial_terminal_ready_out_b <= !v[0];
      @(posedge hclk);
      #1;
      chk({port_b_tx_element_timing_oe, port_b_rx_element_timing_oe}, 2'h0);
      chk(serial_rx_clock_in_b, v[0]);
      chk({dtr_oe, dtr_out}, {1'b1, !v[0]});
    end
    $display("Serial test done");
  endtask

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    // Reset is low from time zero and held for six edges
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (50) @(posedge hclk);
    t_timeout();
    t_reset();
    t_bus();
    t_irq();
    t_serial();
    final_report();
  end

  // Watchdog: whole run is a few hundred cycles
  initial begin
    #200000;
    error_cnt++;
    final_report();
  end
endmodule
`default_nettype wire
